/* File: core/wtk_defs.vh */
// constants for the watchdog timekeeper register block
`ifndef WTK_DEFS_VH
`define WTK_DEFS_VH

// ********************************************************
// register offsets
// ********************************************************
`define WTK_HUNDREDTHS_SECONDS 4'h0
`define WTK_SECONDS_COUNT      4'h1
`define WTK_MINUTES_COUNT      4'h2
`define WTK_MINUTE_ALARM       4'h3
`define WTK_HOURS_COUNT        4'h4
`define WTK_HOUR_ALARM         4'h5
`define WTK_WEEKDAY_COUNT      4'h6
`define WTK_WEEKDAY_ALARM      4'h7
`define WTK_DATE_COUNT         4'h8
`define WTK_MONTH_AND_OSC      4'h9
`define WTK_COMMAND_CONTROL    4'hb
`define WTK_WATCHDOG_FRACTION  4'hc
`define WTK_WATCHDOG_SECONDS   4'hd

// ********************************************************
// field positions
// ********************************************************
`define WTK_ALARM_MASK_BIT     7
`define WTK_HOUR_12H_BIT       6
`define WTK_HOUR_PM_BIT        5
`define WTK_MONTH_OSC_BIT      7
`define WTK_CMD_TE_BIT         7
`define WTK_CMD_SRC_BIT        6
`define WTK_CMD_PULSE_BIT      4
`define WTK_CMD_WD_MASK_BIT    3
`define WTK_CMD_TOD_MASK_BIT   2

// ********************************************************
// reset values
// ********************************************************
`define WTK_RST_COMMAND        8'h80
`define WTK_RST_TIME           8'h00
`define WTK_RST_ONE            8'h01
`define WTK_RST_MONTH          8'h41

// ********************************************************
// timing
// ********************************************************
`define WTK_CLK_HZ             250000000
`define WTK_TOD_TICK_HZ        100
`define WTK_TICK_CYCLES        (`WTK_CLK_HZ / `WTK_TOD_TICK_HZ)
`define WTK_PULSE_MS           3
`define WTK_PULSE_CYCLES       ((`WTK_PULSE_MS * `WTK_CLK_HZ + 999) / 1000)

`endif

/* File: core/wtk_regs.v */
// timekeeping and watchdog register block with one interrupt output
//
// Summary of operation
// [R01] seconds/minutes are bcd, tens above units; bit 7 reads zero
// [R02] hours bit 6 picks 12-hour; bit 4 tens, bit 5 pm
// [R03] 24-hour: bits 5-4 tens, 00-23; bit 7 reads zero
// [R04] weekday number held in bits 2-0, counting 1 to 7
// [R05] date bcd 01-31, tens in bits 5-4; bits 7-6 read zero
// [R06] month bcd 01-12, tens in bit 4; bit 5 reads zero
// [R07] software writes month bit 6 as one
// [R08] month bit 7 high stops the oscillator, low runs it
// [R09] transfer enable low freezes visible copies; counting continues
// [R10] software freezes copies, reads time, then re-enables transfer
// [R11] alarm regs match minutes, hours, day; bit 7 masks
// [R12] masked fields are skipped; all masked fires each minute
// [R13] any access to alarm regs clears time-of-day flag; an alarm hit in the same cycle sets the flag instead
// [R14] watchdog interval is bcd hundredths up to 99.99 seconds
// [R15] watchdog access reloads countdown and clears flag and output
// [R16] countdown at zero raises alarm and restarts, repeating
// [R17] watchdog reads give interval; zero interval disables alarm
// [R18] command bit 6 routes watchdog (0) or time-of-day (1)
// [R19] command bit 4 picks level (0) or pulse of 3 ms (1)
// [R20] software writes bit 5 as zero; bit 5 has no function here
// [R21] command bits 3 and 2 mask watchdog and time-of-day
// [R22] command bits 1,0 are read-only flags; pulse mode tracks output
`timescale 1ns/1ps
`default_nettype none
`include "wtk_defs.vh"

module wtk_regs #(
    parameter integer TICK_CYCLES  = `WTK_TICK_CYCLES,
    parameter integer PULSE_CYCLES = `WTK_PULSE_CYCLES
) (
    input  wire       clock,
    input  wire       rst_b,
    input  wire [3:0] reg_addr,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_wdata,
    output wire [7:0] reg_rdata,
    output wire       irq_b
);

    // ********************************************************
    // state
    // ********************************************************
    reg  [7:0]  hund_ff, sec_ff, min_ff, hour_ff;
    reg  [7:0]  wday_ff, date_ff, month_ff;
    reg  [7:0]  vis_ff [0:9];
    reg  [7:0]  cmd_ff;
    reg  [7:0]  wd_frac_ff, wd_sec_ff;
    reg  [13:0] wd_cnt_ff;
    reg  [21:0] div_ff;
    reg  [19:0] pls_ff [0:1];
    reg  [1:0]  flag_ff;
    reg         irq_b_ff;
    reg  [7:0]  rdata_ff;
    reg  [7:0]  nxt_hund, nxt_sec, nxt_min, nxt_hour;
    reg  [7:0]  nxt_wday, nxt_date, nxt_month;
    reg         min_carry, hour_carry, day_carry;
    reg         tod_hit;

    wire        wr_t = reg_wr;
    wire        acc  = reg_wr | reg_rd;
    wire        osc_run = ~month_ff[`WTK_MONTH_OSC_BIT];
    wire        tick = osc_run &&
                       (div_ff == TICK_CYCLES[21:0] - 22'h00_0001);
    wire        pulse_mode = cmd_ff[`WTK_CMD_PULSE_BIT];

    // ********************************************************
    // bcd helpers
    // ********************************************************
    function [7:0] bcd_inc;
        input [7:0] v;
        begin
            if (v[3:0] == 4'h9) begin
                bcd_inc = {v[7:4] + 4'h1, 4'h0};
            end else begin
                bcd_inc = {v[7:4], v[3:0] + 4'h1};
            end
        end
    endfunction

    // february fixed at 28 days: no year is kept here
    function [7:0] last_date;
        input [4:0] m;
        begin
            case (m)
                5'h02:   last_date = 8'h28;
                5'h04, 5'h06, 5'h09, 5'h11: last_date = 8'h30;
                default: last_date = 8'h31;
            endcase
        end
    endfunction

    // ********************************************************
    // oscillator divider, 100 hz tick
    // ********************************************************
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            div_ff <= 22'h00_0000;
        end else if (!osc_run || tick) begin
            div_ff <= 22'h00_0000;
        end else begin
            div_ff <= div_ff + 22'h00_0001;
        end
    end

    // ********************************************************
    // internal time counters
    // ********************************************************
    always @* begin
        nxt_hund   = hund_ff;
        nxt_sec    = sec_ff;
        nxt_min    = min_ff;
        nxt_hour   = hour_ff;
        nxt_wday   = wday_ff;
        nxt_date   = date_ff;
        nxt_month  = month_ff;
        min_carry  = 1'b0;
        hour_carry = 1'b0;
        day_carry  = 1'b0;
        if (tick) begin
            if (hund_ff == 8'h99) begin
                nxt_hund = 8'h00;
                // [R01] seconds wrap at 59
                if (sec_ff[6:0] == 7'h59) begin
                    nxt_sec   = 8'h00;
                    min_carry = 1'b1;
                end else begin
                    nxt_sec = bcd_inc(sec_ff);
                end
            end else begin
                nxt_hund = bcd_inc(hund_ff);
            end
        end
        if (min_carry) begin
            // [R01] minutes wrap at 59
            if (min_ff[6:0] == 7'h59) begin
                nxt_min    = 8'h00;
                hour_carry = 1'b1;
            end else begin
                nxt_min = bcd_inc(min_ff);
            end
        end
        if (hour_carry) begin
            if (hour_ff[`WTK_HOUR_12H_BIT]) begin
                // [R02] 12-hour sequence with am/pm
                if (hour_ff[4:0] == 5'h12) begin
                    nxt_hour = {hour_ff[7:5], 5'h01};
                end else if (hour_ff[4:0] == 5'h11) begin
                    nxt_hour = {2'b01, ~hour_ff[5], 5'h12};
                    day_carry = hour_ff[5];
                end else begin
                    nxt_hour = bcd_inc(hour_ff) & 8'h7f;
                end
            end else begin
                // [R03] 24-hour wrap after 23
                if (hour_ff[5:0] == 6'h23) begin
                    nxt_hour  = 8'h00;
                    day_carry = 1'b1;
                end else begin
                    nxt_hour = bcd_inc(hour_ff) & 8'h3f;
                end
            end
        end
        if (day_carry) begin
            // [R04] weekday 7 wraps to 1
            nxt_wday = (wday_ff[2:0] == 3'h7) ? 8'h01 :
                       {5'h00, wday_ff[2:0] + 3'h1};
            // [R05] date wraps at month end
            if (date_ff == last_date(month_ff[4:0])) begin
                nxt_date = 8'h01;
                // [R06] month wraps after 12
                nxt_month = (month_ff[4:0] == 5'h12) ?
                            {month_ff[7:5], 5'h01} :
                            (bcd_inc(month_ff) & 8'hdf);
            end else begin
                nxt_date = bcd_inc(date_ff);
            end
        end
        // software writes win over the tick in the same cycle
        if (wr_t) begin
            case (reg_addr)
                `WTK_HUNDREDTHS_SECONDS: nxt_hund = reg_wdata;
                // [R01] bit 7 forced to zero
                `WTK_SECONDS_COUNT: nxt_sec = {1'b0, reg_wdata[6:0]};
                `WTK_MINUTES_COUNT: nxt_min = {1'b0, reg_wdata[6:0]};
                // [R03] hours bit 7 forced to zero
                `WTK_HOURS_COUNT:   nxt_hour = {1'b0, reg_wdata[6:0]};
                // [R04] weekday keeps bits 2-0
                `WTK_WEEKDAY_COUNT: nxt_wday = {5'h00, reg_wdata[2:0]};
                // [R05] date bits 7-6 forced to zero
                `WTK_DATE_COUNT:    nxt_date = {2'b00, reg_wdata[5:0]};
                // [R06] month bit 5 zero; [R07] bit 6 kept as written
                `WTK_MONTH_AND_OSC: nxt_month = {reg_wdata[7:6], 1'b0,
                                                 reg_wdata[4:0]};
                default: ;
            endcase
        end
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            hund_ff  <= `WTK_RST_TIME;
            sec_ff   <= `WTK_RST_TIME;
            min_ff   <= `WTK_RST_TIME;
            hour_ff  <= `WTK_RST_TIME;
            wday_ff  <= `WTK_RST_ONE;
            date_ff  <= `WTK_RST_ONE;
            month_ff <= `WTK_RST_MONTH;
        end else begin
            hund_ff  <= nxt_hund;
            sec_ff   <= nxt_sec;
            min_ff   <= nxt_min;
            hour_ff  <= nxt_hour;
            wday_ff  <= nxt_wday;
            date_ff  <= nxt_date;
            // [R08] oscillator bit may change at any time
            month_ff <= nxt_month;
        end
    end

    // ********************************************************
    // visible copies and alarm registers
    // ********************************************************
    // while frozen, a write refreshes only its own copy, not all of them
    wire [15:0] wdec = wr_t ? (16'h0001 << reg_addr) : 16'h0000;
    wire [9:0]  csel = cmd_ff[`WTK_CMD_TE_BIT] ? 10'h3ff : wdec[9:0];
    integer i;
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            for (i = 0; i < 10; i = i + 1) begin
                vis_ff[i] <= `WTK_RST_TIME;
            end
            vis_ff[6] <= `WTK_RST_ONE;
            vis_ff[8] <= `WTK_RST_ONE;
            vis_ff[9] <= `WTK_RST_MONTH;
        end else begin
            // [R09] copies track only while transfer is enabled
            if (csel[0]) vis_ff[0] <= nxt_hund;
            if (csel[1]) vis_ff[1] <= nxt_sec;
            if (csel[2]) vis_ff[2] <= nxt_min;
            if (csel[4]) vis_ff[4] <= nxt_hour;
            if (csel[6]) vis_ff[6] <= nxt_wday;
            if (csel[8]) vis_ff[8] <= nxt_date;
            if (csel[9]) vis_ff[9] <= nxt_month;
            // [R11] alarm regs keep mask bit 7
            if (wdec[3]) vis_ff[3] <= reg_wdata;
            if (wdec[5]) vis_ff[5] <= reg_wdata;
            if (wdec[7]) vis_ff[7] <= {reg_wdata[7], 4'h0, reg_wdata[2:0]};
        end
    end

    // ********************************************************
    // time-of-day alarm compare
    // ********************************************************
    always @* begin
        // [R12] fires as seconds roll 59 to 00, masked fields skipped
        // [R11] unmasked fields must equal the new time
        tod_hit = min_carry &&
            (vis_ff[3][`WTK_ALARM_MASK_BIT] ||
             vis_ff[3][6:0] == nxt_min[6:0]) &&
            (vis_ff[5][`WTK_ALARM_MASK_BIT] ||
             vis_ff[5][6:0] == nxt_hour[6:0]) &&
            (vis_ff[7][`WTK_ALARM_MASK_BIT] ||
             vis_ff[7][2:0] == nxt_wday[2:0]);
    end

    // ********************************************************
    // watchdog
    // ********************************************************
    wire        wd_acc = acc && (reg_addr == `WTK_WATCHDOG_FRACTION ||
                                 reg_addr == `WTK_WATCHDOG_SECONDS);
    wire        tod_acc = acc && (reg_addr == `WTK_MINUTE_ALARM ||
                                  reg_addr == `WTK_HOUR_ALARM ||
                                  reg_addr == `WTK_WEEKDAY_ALARM);
    wire [7:0]  wd_frac_new = (reg_wr && reg_addr ==
                   `WTK_WATCHDOG_FRACTION) ? reg_wdata : wd_frac_ff;
    wire [7:0]  wd_sec_new = (reg_wr && reg_addr ==
                   `WTK_WATCHDOG_SECONDS) ? reg_wdata : wd_sec_ff;
    // [R14] bcd interval converted to hundredths
    wire [13:0] wd_ivl = {10'h000, wd_sec_new[7:4]} * 14'd1000 +
                         {10'h000, wd_sec_new[3:0]} * 14'd100 +
                         {10'h000, wd_frac_new[7:4]} * 14'd10 +
                         {10'h000, wd_frac_new[3:0]};
    // [R17] zero interval never fires
    wire        wd_hit = tick && !wd_acc && wd_ivl != 14'h0000 &&
                         wd_cnt_ff <= 14'h0001;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wd_frac_ff <= `WTK_RST_TIME;
            wd_sec_ff  <= `WTK_RST_TIME;
            wd_cnt_ff  <= 14'h0000;
        end else begin
            wd_frac_ff <= wd_frac_new;
            wd_sec_ff  <= wd_sec_new;
            // [R15] any access reloads the countdown
            if (wd_acc) begin
                wd_cnt_ff <= wd_ivl;
            // [R16] restart after reaching zero
            end else if (wd_hit) begin
                wd_cnt_ff <= wd_ivl;
            end else if (tick && wd_cnt_ff != 14'h0000) begin
                wd_cnt_ff <= wd_cnt_ff - 14'h0001;
            end
        end
    end

    // ********************************************************
    // alarm flags, pulse timers and output
    // ********************************************************
    // index 0 time-of-day, index 1 watchdog
    wire [1:0] hit = {wd_hit, tod_hit};
    wire [1:0] clr = {wd_acc, tod_acc};

    integer k;
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            flag_ff   <= 2'b00;
            pls_ff[0] <= 20'h0_0000;
            pls_ff[1] <= 20'h0_0000;
        end else begin
            for (k = 0; k < 2; k = k + 1) begin
                // [R22] a new time-of-day alarm wins over a clearing access; a watchdog access blocks wd_hit
                if (hit[k]) begin
                    flag_ff[k] <= 1'b1;
                    pls_ff[k]  <= PULSE_CYCLES[19:0] - 20'h0_0001;
                // [R13] [R15] access clears the flag and output
                end else if (clr[k]) begin
                    flag_ff[k] <= 1'b0;
                    pls_ff[k]  <= 20'h0_0000;
                // [R19] pulse flag ends after the pulse time
                end else if (pulse_mode && flag_ff[k]) begin
                    if (pls_ff[k] == 20'h0_0000) begin
                        flag_ff[k] <= 1'b0;
                    end else begin
                        pls_ff[k] <= pls_ff[k] - 20'h0_0001;
                    end
                end
            end
        end
    end

    // [R18] source select; [R21] per-source mask
    wire irq_act = cmd_ff[`WTK_CMD_SRC_BIT] ?
                   (flag_ff[0] & ~cmd_ff[`WTK_CMD_TOD_MASK_BIT]) :
                   (flag_ff[1] & ~cmd_ff[`WTK_CMD_WD_MASK_BIT]);

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq_b_ff <= 1'b1;
        end else begin
            irq_b_ff <= ~irq_act;
        end
    end

    // ********************************************************
    // command register and read port
    // ********************************************************
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cmd_ff <= `WTK_RST_COMMAND;
        end else if (reg_wr && reg_addr == `WTK_COMMAND_CONTROL) begin
            // [R22] flag bits 1-0 are not writable
            cmd_ff <= {reg_wdata[7:2], 2'b00};
        end
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `WTK_HUNDREDTHS_SECONDS: rdata_ff <= vis_ff[0];
                `WTK_SECONDS_COUNT:      rdata_ff <= vis_ff[1];
                `WTK_MINUTES_COUNT:      rdata_ff <= vis_ff[2];
                `WTK_MINUTE_ALARM:       rdata_ff <= vis_ff[3];
                `WTK_HOURS_COUNT:        rdata_ff <= vis_ff[4];
                `WTK_HOUR_ALARM:         rdata_ff <= vis_ff[5];
                `WTK_WEEKDAY_COUNT:      rdata_ff <= vis_ff[6];
                `WTK_WEEKDAY_ALARM:      rdata_ff <= vis_ff[7];
                `WTK_DATE_COUNT:         rdata_ff <= vis_ff[8];
                `WTK_MONTH_AND_OSC:      rdata_ff <= vis_ff[9];
                `WTK_COMMAND_CONTROL:
                    rdata_ff <= {cmd_ff[7:2], flag_ff[1], flag_ff[0]};
                // [R17] reads give the entered interval, not the count
                `WTK_WATCHDOG_FRACTION:  rdata_ff <= wd_frac_ff;
                `WTK_WATCHDOG_SECONDS:   rdata_ff <= wd_sec_ff;
                default:                 rdata_ff <= 8'h00;
            endcase
        end
    end

    assign reg_rdata = rdata_ff;
    assign irq_b     = irq_b_ff;

endmodule // wtk_regs
`default_nettype wire

/* File: bench/wtk_regs_properties.sv */
// concurrent checks for the watchdog timekeeper register block
`timescale 1ns/1ps
`default_nettype none
module wtk_regs_properties #(
    parameter integer TICK_CYCLES  = 10,
    parameter integer PULSE_CYCLES = 5
) (
    input wire logic       clock,
    input wire logic       rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       irq_b
);
    // ********************************************************
    // shadow of the written control state
    // ********************************************************
    logic [7:0] cmd_ff;
    logic [7:0] wd_lo_ff;
    logic       wd_acc;
    logic       tod_acc;
    logic       quiet;
    logic       irq_en;

    assign wd_acc  = (reg_wr | reg_rd) && reg_addr[3:1] == 3'h6;
    assign tod_acc = (reg_wr | reg_rd) && (reg_addr == 4'h3
                     || reg_addr == 4'h5 || reg_addr == 4'h7);
    // a command write can end a pulse early
    assign quiet   = !(wd_acc || tod_acc || (reg_wr && reg_addr == 4'hb));
    assign irq_en  = cmd_ff[6] ? !cmd_ff[2] : !cmd_ff[3];

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cmd_ff   <= 8'h80;
            wd_lo_ff <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == 4'hb)
                cmd_ff <= reg_wdata;
            if (reg_wr && reg_addr == 4'hc)
                wd_lo_ff <= reg_wdata;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    // ********************************************************
    // properties
    // ********************************************************
    time_top_zero_a:
    assert property (reg_rd && (reg_addr == 4'h1 || reg_addr == 4'h2
        || reg_addr == 4'h4) |=> !reg_rdata[7])
        else $error("time register bit 7 read as one");
    date_top_zero_a:
    assert property (reg_rd && reg_addr == 4'h8 |=> reg_rdata[7:6] == 2'h0)
        else $error("date bits 7-6 read as nonzero");
    month_b5_zero_a:
    assert property (reg_rd && reg_addr == 4'h9 |=> !reg_rdata[5])
        else $error("month bit 5 read as one");
    wd_readback_a:
    assert property (reg_rd && reg_addr == 4'hc
        |=> reg_rdata == $past(wd_lo_ff))
        else $error("watchdog fraction read differs from entry");
    wd_clear_a:
    assert property (wd_acc && !cmd_ff[6] |-> ##2 irq_b)
        else $error("watchdog access did not clear output");
    tod_clear_a:
    assert property (tod_acc && cmd_ff[6] |-> ##2 irq_b)
        else $error("alarm register access did not clear output");
    mask_hold_a:
    assert property ($past(!irq_en) |-> irq_b)
        else $error("masked source drove the output");
    flag_level_a:
    assert property (reg_rd && reg_addr == 4'hb && !irq_b && !cmd_ff[4]
        && !cmd_ff[6] && !$past(wd_acc) |=> reg_rdata[1])
        else $error("watchdog flag clear while output active");
    cmd_readback_a:
    assert property (reg_rd && reg_addr == 4'hb |=> {reg_rdata[7:6],
        reg_rdata[4:2]} == $past({cmd_ff[7:6], cmd_ff[4:2]}))
        else $error("command control bits read back wrong");
    // five low cycles, as the bench pulse
    pulse_hold_a:
    assert property ($fell(irq_b) && cmd_ff[4] && quiet ##1 quiet[*4]
        |-> !irq_b)
        else $error("pulse output ended too soon");

    cover property ($fell(irq_b) && cmd_ff[4]);
    cover property (wd_acc && !irq_b);
    cover property (tod_acc && cmd_ff[6] && !irq_b);
endmodule // wtk_regs_properties
`default_nettype wire

/* File: bench/wtk_regs_bench.sv */
// self-checking bench for the watchdog timekeeper register block
`timescale 1ns/1ps
`default_nettype none
module wtk_regs_bench;
    localparam integer PULSE = 5;
    // offset, value written, value read back
    localparam logic [7:0] FLD [0:4][0:2] = '{
        '{8'h01, 8'hd9, 8'h59}, '{8'h02, 8'hd9, 8'h59},
        '{8'h04, 8'ha3, 8'h23}, '{8'h08, 8'hf1, 8'h31},
        '{8'h09, 8'hf2, 8'hd2}};
    // hours in, weekday in, hours out, weekday out
    localparam logic [7:0] ROLL [0:2][0:3] = '{
        '{8'h23, 8'h07, 8'h00, 8'h01}, '{8'h71, 8'h01, 8'h52, 8'h02},
        '{8'h51, 8'h03, 8'h72, 8'h03}};
    // command, minute, hour, day alarm, flag, output
    localparam logic [7:0] TOD [0:6][0:5] = '{
        '{8'hc0, 8'h80, 8'h80, 8'h80, 8'h01, 8'h01},
        '{8'hc0, 8'h06, 8'h80, 8'h80, 8'h01, 8'h01},
        '{8'hc0, 8'h07, 8'h80, 8'h80, 8'h00, 8'h00},
        '{8'hc0, 8'h06, 8'h00, 8'h02, 8'h01, 8'h01},
        '{8'hc0, 8'h06, 8'h00, 8'h03, 8'h00, 8'h00},
        '{8'hc4, 8'h80, 8'h80, 8'h80, 8'h01, 8'h00},
        '{8'h80, 8'h80, 8'h80, 8'h80, 8'h01, 8'h00}};
    logic       clock;
    logic       rst_b;
    logic [3:0] reg_addr;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_wdata;
    wire  [7:0] reg_rdata;
    wire        irq_b;
    int         error_cnt;
    int         tests_run;

    wtk_regs #(.TICK_CYCLES(10), .PULSE_CYCLES(PULSE)) i_dut (
        .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .irq_b(irq_b));

    // ********************************************************
    // shared tasks
    // ********************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h wanted %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        d      = reg_rdata;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask
    // stops at the first low sample
    task automatic wait_fall(input int n, output logic [7:0] seen);
        seen = 8'h00;
        for (int i = 0; i < n && seen == 8'h00; i++) begin
            @(negedge clock);
            if (irq_b === 1'b0)
                seen = 8'h01;
        end
    endtask
    task automatic irq_high;
        @(negedge clock);
        chk({7'h00, irq_b}, 8'h01);
    endtask
    task automatic final_report;
        if (error_cnt == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ********************************************************
    // scenarios
    // ********************************************************
    task automatic t_reset_values;
        rdc(4'hb, 8'h80);
        rdc(4'h9, 8'h41);
        rdc(4'h6, 8'h01);
        rdc(4'h8, 8'h01);
        rdc(4'hd, 8'h00);
        wr(4'ha, 8'h5a);
        rdc(4'ha, 8'h00);
    endtask
    task automatic t_fields;
        logic [7:0] h;
        wr(4'h9, 8'hc1);
        foreach (FLD[i]) begin
            wr(FLD[i][0][3:0], FLD[i][1]);
            rdc(FLD[i][0][3:0], FLD[i][2]);
        end
        rd(4'h0, h);
        repeat (30) @(negedge clock);
        rdc(4'h0, h);
    endtask
    // time is loaded with the oscillator stopped so no tick splits it
    task automatic t_roll;
        logic [7:0] h;
        logic [7:0] h2;
        foreach (ROLL[i]) begin
            wr(4'h9, 8'hc1);
            wr(4'h4, ROLL[i][0]);
            wr(4'h6, ROLL[i][1]);
            wr(4'h2, 8'h59);
            wr(4'h1, 8'h59);
            wr(4'h0, 8'h99);
            wr(4'h9, 8'h41);
            repeat (15) @(negedge clock);
            wr(4'hb, 8'h00);
            rdc(4'h4, ROLL[i][2]);
            rdc(4'h6, ROLL[i][3]);
            rdc(4'h2, 8'h00);
            wr(4'hb, 8'h80);
        end
        wr(4'hb, 8'h00);
        rd(4'h0, h);
        repeat (30) @(negedge clock);
        rdc(4'h0, h);
        wr(4'hb, 8'h80);
        rd(4'h0, h2);
        chk({7'h00, h2 !== h}, 8'h01);
    endtask
    task automatic t_wd;
        logic [7:0] f;
        logic [7:0] d;
        wr(4'hb, 8'h80);
        wr(4'hd, 8'h01);
        rdc(4'hd, 8'h01);
        wr(4'hd, 8'h00);
        wr(4'hc, 8'h02);
        wait_fall(40, f);
        chk(f, 8'h01);
        repeat (10) @(negedge clock);
        chk({7'h00, irq_b}, 8'h00);
        rd(4'hb, d);
        chk({7'h00, d[1]}, 8'h01);
        rdc(4'hc, 8'h02);
        irq_high;
        wr(4'hb, 8'h90);
        wait_fall(40, f);
        chk(f, 8'h01);
        repeat (PULSE + 3) @(negedge clock);
        chk({7'h00, irq_b}, 8'h01);
        rd(4'hb, d);
        chk({7'h00, d[1]}, 8'h00);
        wait_fall(40, f);
        chk(f, 8'h01);
        wr(4'hb, 8'h88);
        rdc(4'hc, 8'h02);
        wait_fall(50, f);
        chk(f, 8'h00);
        rd(4'hb, d);
        chk({7'h00, d[1]}, 8'h01);
        wr(4'hc, 8'h00);
        wr(4'hb, 8'h80);
        wait_fall(50, f);
        chk(f, 8'h00);
    endtask
    task automatic t_tod;
        logic [7:0] f;
        logic [7:0] d;
        foreach (TOD[i]) begin
            wr(4'h9, 8'hc1);
            wr(4'h4, 8'h00);
            wr(4'h6, 8'h02);
            wr(4'h2, 8'h05);
            wr(4'h1, 8'h59);
            wr(4'h0, 8'h99);
            wr(4'h3, TOD[i][1]);
            wr(4'h5, TOD[i][2]);
            wr(4'h7, TOD[i][3]);
            wr(4'hb, TOD[i][0]);
            wr(4'h9, 8'h41);
            wait_fall(30, f);
            chk(f, TOD[i][5]);
            rd(4'hb, d);
            chk({7'h00, d[0]}, TOD[i][4]);
            rd(4'h5, d);
            irq_high;
        end
    endtask

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        error_cnt = 0;
        tests_run = 0;
        rst_b     = 1'b0;
        reg_addr  = 4'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
        repeat (16) @(negedge clock);
        rst_b = 1'b1;
        t_reset_values;
        t_fields;
        t_roll;
        t_wd;
        t_tod;
        final_report;
    end
    initial begin
        #200_000;
        error_cnt++;
        $display("mismatch at %0t: run timed out", $time);
        final_report;
    end
endmodule // wtk_regs_bench

bind wtk_regs wtk_regs_properties #(
    .TICK_CYCLES(TICK_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) i_props (
    .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .irq_b(irq_b));
`default_nettype wire
